// ===== shared/drive_psm_pkg.sv
package drive_psm_pkg;

	// Register indices; byte address is four times the index
	localparam int unsigned   ADDR_W       = 18;
	localparam logic [15:0]   IDX_CTRL     = 16'h6040;
	localparam logic [15:0]   IDX_STATUS   = 16'h6041;
	localparam logic [15:0]   IDX_MODE_REQ = 16'h6060;
	localparam logic [15:0]   IDX_MODE_ACT = 16'h6061;
	localparam logic [15:0]   IDX_OPT_QS   = 16'h605a;
	localparam logic [15:0]   IDX_OPT_SHUT = 16'h605b;
	localparam logic [15:0]   IDX_OPT_DOP  = 16'h605c;
	localparam logic [15:0]   IDX_OPT_HALT = 16'h605d;
	localparam logic [15:0]   IDX_OPT_FLT  = 16'h605e;
	localparam logic [15:0]   IDX_FE_WIN   = 16'h6065;
	localparam logic [15:0]   IDX_SLIP     = 16'h60f8;
	localparam logic [15:0]   IDX_OPT_FERR = 16'h3700;

	// Request word bit positions
	localparam int unsigned   CW_SWITCH_ON = 0;
	localparam int unsigned   CW_VOLTAGE   = 1;
	localparam int unsigned   CW_QSTOP_N   = 2;
	localparam int unsigned   CW_ENABLE_OP = 3;
	localparam int unsigned   CW_FLT_RESET = 7;
	localparam int unsigned   CW_HALT      = 8;

	// Report word bit positions
	localparam int unsigned   SW_READY     = 0;
	localparam int unsigned   SW_ON        = 1;
	localparam int unsigned   SW_OP_EN     = 2;
	localparam int unsigned   SW_FAULT     = 3;
	localparam int unsigned   SW_QSTOP_N   = 5;
	localparam int unsigned   SW_DISABLED  = 6;

	// Reset values
	localparam logic [15:0]   RST_CTRL     = 16'h0000;
	localparam logic [15:0]   RST_OPT      = 16'h0000;
	localparam logic [7:0]    RST_MODE     = 8'h00;
	localparam logic [31:0]   RST_FE_WIN   = 32'hffff_ffff;
	localparam logic [31:0]   RST_SLIP     = 32'h0000_0000;

	// Monitoring switched off by these values
	localparam logic [31:0]   FE_WIN_OFF   = 32'hffff_ffff;
	localparam logic [31:0]   SLIP_OFF     = 32'h7fff_ffff;

	// Stop option codes
	localparam logic [15:0]   OPT_IMM      = 16'h0000;
	localparam logic [15:0]   OPT_SLOW     = 16'h0001;
	localparam logic [15:0]   OPT_QUICK    = 16'h0002;

	// Modes in which the halt bit acts
	localparam logic [7:0]    MODE_PP      = 8'h01;
	localparam logic [7:0]    MODE_VEL     = 8'h02;
	localparam logic [7:0]    MODE_PV      = 8'h03;
	localparam logic [7:0]    MODE_PT      = 8'h04;
	localparam logic [7:0]    MODE_IP      = 8'h07;

	typedef enum logic [2:0] {
		ST_NOT_READY,
		ST_DISABLED,
		ST_READY,
		ST_SWITCHED_ON,
		ST_OP_ENABLED,
		ST_QUICK_STOP,
		ST_FAULT_REACT,
		ST_FAULT
	} psm_state_t;

	typedef enum logic [1:0] {
		STOP_IMM,
		STOP_SLOW,
		STOP_QUICK,
		STOP_NONE
	} stop_act_t;

	typedef struct packed {
		logic immediate;
		logic slow_ramp;
		logic quick_ramp;
	} brake_t;

	typedef struct packed {
		logic shutdown;
		logic switch_on;
		logic disable_voltage;
		logic quick_stop;
		logic enable_op;
	} psm_cmd_t;

endpackage

// ===== rtl/stop_option_decoder.sv
`timescale 1ns/100ps
module stop_option_decoder
	import drive_psm_pkg::*;
#(
	parameter bit        ALLOW_IMM    = 1'b1,
	parameter bit        ALLOW_SLOW   = 1'b1,
	parameter bit        ALLOW_QUICK  = 1'b1,
	parameter stop_act_t RESERVED_ACT = STOP_IMM
)(
	input  wire logic [15:0] code,
	output stop_act_t        act
);

	// Reserved codes fall back to a safe fixed reaction
	always_comb begin
		if (ALLOW_IMM && code == OPT_IMM) begin
			act = STOP_IMM;
		end else if (ALLOW_SLOW && code == OPT_SLOW) begin
			act = STOP_SLOW;
		end else if (ALLOW_QUICK && code == OPT_QUICK) begin
			act = STOP_QUICK;
		end else begin
			act = RESERVED_ACT;
		end
	end

endmodule

// ===== rtl/drive_power_state_machine.sv
// Added by the designer: the APB interface to the registers.
`timescale 1ns/100ps
// Function
// R1 - Master writes request word for state changes; state shows only in report word.
// R2 - Decode request bits 7,3,2,1,0 into shutdown, switch on, disable, quick stop, enable.
// R3 - Fault reset only on a rising edge of request bit 7.
// R4 - Report word bits 6,5,3..0 encode each of the eight states.
// R5 - After passed self-test, enter switch on disabled.
// R6 - Unrecoverable error forces not ready to switch on permanently.
// R7 - Mode request writable anytime; active mode shown in separate read-only word.
// R8 - Quick stop option: 0 immediate, 1 slow ramp, 2 quick ramp, then disabled.
// R9 - Shutdown option: 0 immediate, 1 slow ramp then switch on disabled.
// R10 - Disable operation option: 0 immediate, 1 slow ramp then switch on disabled.
// R11 - Halt bit applies halt option: 1 slow ramp, 2 quick ramp.
// R12 - Halt acts only in PP, velocity, PV, torque and interpolated modes.
// R13 - Fault brakes per fault option: 0 immediate, 1 slow, 2 quick.
// R14 - Following or slippage error brakes per its own option code.
// R15 - Error monitoring off when window is all ones or limit is maximum positive.
// R16 - Switch on and disable operation share a pattern; current state tells them apart.
// R17 - After a ramped stop, state changes only at standstill; report holds old state.
module drive_power_state_machine
	import drive_psm_pkg::*;
(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              self_test_pass,
	input  wire logic              unrecoverable_err,
	input  wire logic              fault_event,
	input  wire logic              follow_err_event,
	input  wire logic              motor_standstill,
	output brake_t                 brake,
	output logic                   drive_enable,
	output logic                   monitor_enable,
	output logic      [7:0]        mode_active
);

	logic [15:0] ctrl_r;
	logic [15:0] opt_qs_r;
	logic [15:0] opt_shut_r;
	logic [15:0] opt_dop_r;
	logic [15:0] opt_halt_r;
	logic [15:0] opt_flt_r;
	logic [15:0] opt_ferr_r;
	logic [7:0]  mode_req_r;
	logic [7:0]  mode_act_r;
	logic [31:0] fe_win_r;
	logic [31:0] slip_r;
	logic [31:0] prdata_r;
	logic        err_r;
	logic        unrec_r;
	logic        fr_prev_r;
	logic        pend_r;
	logic        pend_nxt;
	logic        drive_en_r;
	psm_state_t  state_r;
	psm_state_t  state_nxt;
	psm_state_t  target_r;
	psm_state_t  target_nxt;
	stop_act_t   pend_act_r;
	stop_act_t   pend_act_nxt;
	brake_t      brake_r;
	brake_t      brake_nxt;
	psm_cmd_t    cmd;
	stop_act_t   qs_act;
	stop_act_t   shut_act;
	stop_act_t   dop_act;
	stop_act_t   halt_act;
	stop_act_t   flt_act;
	stop_act_t   ferr_act;
	logic [15:0] status_w;
	logic [15:0] idx;
	logic        wr_en;
	logic        setup;
	logic        fr_edge;
	logic        halt_mode_ok;
	logic        ferr_hit;
	logic        fault_any;
	logic        unrec_any;

	function automatic brake_t act_to_brake(stop_act_t a);
		brake_t b;
		b = '0;
		b.immediate  = (a == STOP_IMM);
		b.slow_ramp  = (a == STOP_SLOW);
		b.quick_ramp = (a == STOP_QUICK);
		return b;
	endfunction

	// Option decoders; reserved codes stop at once except for halt
	stop_option_decoder #(.ALLOW_QUICK(1'b1), .RESERVED_ACT(STOP_IMM)) u_dec_qs (
		.code (opt_qs_r),
		.act  (qs_act)
	); // R8
	stop_option_decoder #(.ALLOW_QUICK(1'b0), .RESERVED_ACT(STOP_IMM)) u_dec_shut (
		.code (opt_shut_r),
		.act  (shut_act)
	); // R9
	stop_option_decoder #(.ALLOW_QUICK(1'b0), .RESERVED_ACT(STOP_IMM)) u_dec_dop (
		.code (opt_dop_r),
		.act  (dop_act)
	); // R10
	stop_option_decoder #(.ALLOW_IMM(1'b0), .RESERVED_ACT(STOP_NONE)) u_dec_halt (
		.code (opt_halt_r),
		.act  (halt_act)
	); // R11
	stop_option_decoder #(.RESERVED_ACT(STOP_IMM)) u_dec_flt (
		.code (opt_flt_r),
		.act  (flt_act)
	); // R13
	stop_option_decoder #(.RESERVED_ACT(STOP_IMM)) u_dec_ferr (
		.code (opt_ferr_r),
		.act  (ferr_act)
	); // R14

	// Command decode from the request word
	always_comb begin
		cmd.shutdown        = !ctrl_r[CW_FLT_RESET] && ctrl_r[CW_QSTOP_N]
		                      && ctrl_r[CW_VOLTAGE] && !ctrl_r[CW_SWITCH_ON]; // R2
		cmd.switch_on       = !ctrl_r[CW_FLT_RESET] && !ctrl_r[CW_ENABLE_OP]
		                      && (ctrl_r[2:0] == 3'b111); // R2
		cmd.disable_voltage = !ctrl_r[CW_FLT_RESET] && !ctrl_r[CW_VOLTAGE]; // R2
		cmd.quick_stop      = !ctrl_r[CW_FLT_RESET] && !ctrl_r[CW_QSTOP_N]
		                      && ctrl_r[CW_VOLTAGE]; // R2
		cmd.enable_op       = !ctrl_r[CW_FLT_RESET] && ctrl_r[CW_ENABLE_OP]
		                      && (ctrl_r[2:0] == 3'b111); // R2
	end

	assign fr_edge        = ctrl_r[CW_FLT_RESET] && !fr_prev_r; // R3
	assign halt_mode_ok   = (mode_act_r == MODE_PP) || (mode_act_r == MODE_VEL)
	                        || (mode_act_r == MODE_PV) || (mode_act_r == MODE_PT)
	                        || (mode_act_r == MODE_IP); // R12
	assign monitor_enable = (fe_win_r != FE_WIN_OFF) && (slip_r != SLIP_OFF); // R15
	assign ferr_hit       = follow_err_event && monitor_enable;
	assign fault_any      = fault_event || ferr_hit;
	assign unrec_any      = unrec_r || unrecoverable_err;

	// Report word from state only
	always_comb begin
		status_w = '0;
		unique case (state_r)
			ST_NOT_READY:   status_w[6:0] = 7'b000_0000;
			ST_DISABLED:    status_w[6:0] = 7'b100_0000;
			ST_READY:       status_w[6:0] = 7'b010_0001;
			ST_SWITCHED_ON: status_w[6:0] = 7'b010_0011;
			ST_OP_ENABLED:  status_w[6:0] = 7'b010_0111;
			ST_QUICK_STOP:  status_w[6:0] = 7'b000_0111;
			ST_FAULT_REACT: status_w[6:0] = 7'b000_1111;
			ST_FAULT:       status_w[6:0] = 7'b000_1000;
		endcase // R4
	end

	// Next state; priority: lock-out, fault, pending stop, commands
	always_comb begin
		state_nxt    = state_r;
		target_nxt   = target_r;
		pend_nxt     = pend_r;
		pend_act_nxt = pend_act_r;
		brake_nxt    = '0;
		if (unrec_any) begin
			state_nxt = ST_NOT_READY; // R6
			pend_nxt  = 1'b0;
			brake_nxt = act_to_brake(STOP_IMM);
		end else if (fault_any && state_r != ST_NOT_READY && state_r != ST_FAULT_REACT
		             && state_r != ST_FAULT) begin
			state_nxt    = ST_FAULT_REACT;
			target_nxt   = ST_FAULT;
			pend_nxt     = 1'b1;
			pend_act_nxt = ferr_hit ? ferr_act : flt_act; // R13 R14
			brake_nxt    = act_to_brake(pend_act_nxt);
		end else if (pend_r) begin
			// Ramped stops wait for standstill; immediate ones finish next cycle
			brake_nxt = act_to_brake(pend_act_r);
			if (pend_act_r == STOP_IMM || motor_standstill) begin
				state_nxt = target_r; // R17
				pend_nxt  = 1'b0;
			end
		end else begin
			unique case (state_r)
				ST_NOT_READY: if (self_test_pass) state_nxt = ST_DISABLED; // R5
				ST_DISABLED: if (cmd.shutdown) state_nxt = ST_READY;
				ST_READY: begin
					if (cmd.disable_voltage || cmd.quick_stop) begin
						state_nxt = ST_DISABLED;
					end else if (cmd.switch_on) begin
						state_nxt = ST_SWITCHED_ON; // R16
					end
				end
				ST_SWITCHED_ON: begin
					if (cmd.disable_voltage || cmd.quick_stop) begin
						state_nxt = ST_DISABLED;
					end else if (cmd.shutdown) begin
						state_nxt = ST_READY;
					end else if (cmd.enable_op) begin
						state_nxt = ST_OP_ENABLED;
					end
				end
				ST_OP_ENABLED: begin
					if (cmd.disable_voltage) begin
						state_nxt = ST_DISABLED;
						brake_nxt = act_to_brake(STOP_IMM);
					end else if (cmd.quick_stop) begin
						state_nxt    = ST_QUICK_STOP; // R8
						target_nxt   = ST_DISABLED;
						pend_nxt     = 1'b1;
						pend_act_nxt = qs_act;
						brake_nxt    = act_to_brake(qs_act);
					end else if (cmd.shutdown) begin
						// Immediate goes straight on; ramp holds state until stopped
						if (shut_act == STOP_IMM) begin
							state_nxt = ST_READY; // R9
							brake_nxt = act_to_brake(STOP_IMM);
						end else begin
							target_nxt   = ST_DISABLED; // R9
							pend_nxt     = 1'b1;
							pend_act_nxt = shut_act;
							brake_nxt    = act_to_brake(shut_act);
						end
					end else if (cmd.switch_on) begin
						if (dop_act == STOP_IMM) begin
							state_nxt = ST_SWITCHED_ON; // R10 R16
							brake_nxt = act_to_brake(STOP_IMM);
						end else begin
							target_nxt   = ST_DISABLED; // R10
							pend_nxt     = 1'b1;
							pend_act_nxt = dop_act;
							brake_nxt    = act_to_brake(dop_act);
						end
					end else if (ctrl_r[CW_HALT] && halt_mode_ok) begin
						brake_nxt = act_to_brake(halt_act); // R11 R12
					end
				end
				ST_QUICK_STOP: if (cmd.disable_voltage) state_nxt = ST_DISABLED;
				ST_FAULT_REACT: state_nxt = ST_FAULT;
				ST_FAULT: if (fr_edge) state_nxt = ST_DISABLED; // R3
			endcase
		end
	end

	// State machine registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r    <= ST_NOT_READY;
			target_r   <= ST_DISABLED;
			pend_r     <= 1'b0;
			pend_act_r <= STOP_IMM;
			brake_r    <= '0;
		end else begin
			state_r    <= state_nxt;
			target_r   <= target_nxt;
			pend_r     <= pend_nxt;
			pend_act_r <= pend_act_nxt;
			brake_r    <= brake_nxt;
		end
	end

	// Sticky lock-out, edge history, power stage enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			unrec_r    <= 1'b0;
			fr_prev_r  <= 1'b0;
			drive_en_r <= 1'b0;
		end else begin
			unrec_r    <= unrec_any; // R6
			fr_prev_r  <= ctrl_r[CW_FLT_RESET];
			drive_en_r <= (state_nxt == ST_OP_ENABLED) || (state_nxt == ST_QUICK_STOP)
			              || (state_nxt == ST_FAULT_REACT);
		end
	end

	// Active mode follows the request except while a stop is pending
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_act_r <= RST_MODE;
		end else if (!pend_r) begin
			mode_act_r <= mode_req_r; // R7
		end
	end

	// APB decode; no wait states
	assign idx   = paddr[17:2];
	assign setup = psel && !penable;
	assign wr_en = psel && penable && pwrite && !err_r;

	// Register writes at the access edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r     <= RST_CTRL;
			opt_qs_r   <= RST_OPT;
			opt_shut_r <= RST_OPT;
			opt_dop_r  <= RST_OPT;
			opt_halt_r <= RST_OPT;
			opt_flt_r  <= RST_OPT;
			opt_ferr_r <= RST_OPT;
			mode_req_r <= RST_MODE;
			fe_win_r   <= RST_FE_WIN;
			slip_r     <= RST_SLIP;
		end else if (wr_en) begin
			unique case (idx)
				IDX_CTRL:     ctrl_r     <= pwdata[15:0]; // R1
				IDX_OPT_QS:   opt_qs_r   <= pwdata[15:0];
				IDX_OPT_SHUT: opt_shut_r <= pwdata[15:0];
				IDX_OPT_DOP:  opt_dop_r  <= pwdata[15:0];
				IDX_OPT_HALT: opt_halt_r <= pwdata[15:0];
				IDX_OPT_FLT:  opt_flt_r  <= pwdata[15:0];
				IDX_OPT_FERR: opt_ferr_r <= pwdata[15:0];
				IDX_MODE_REQ: mode_req_r <= pwdata[7:0]; // R7
				IDX_FE_WIN:   fe_win_r   <= pwdata;
				IDX_SLIP:     slip_r     <= pwdata;
				default:      ;
			endcase
		end
	end

	// Read data and error latched in setup so both stand in access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= '0;
			err_r    <= 1'b0;
		end else if (setup) begin
			prdata_r <= '0;
			err_r    <= 1'b0;
			unique case (idx)
				IDX_CTRL:     prdata_r <= {16'h0000, ctrl_r};
				IDX_STATUS:   begin
					prdata_r <= {16'h0000, status_w}; // R1
					err_r    <= pwrite;
				end
				IDX_OPT_QS:   prdata_r <= {16'h0000, opt_qs_r};
				IDX_OPT_SHUT: prdata_r <= {16'h0000, opt_shut_r};
				IDX_OPT_DOP:  prdata_r <= {16'h0000, opt_dop_r};
				IDX_OPT_HALT: prdata_r <= {16'h0000, opt_halt_r};
				IDX_OPT_FLT:  prdata_r <= {16'h0000, opt_flt_r};
				IDX_OPT_FERR: prdata_r <= {16'h0000, opt_ferr_r};
				IDX_MODE_REQ: prdata_r <= {24'h000000, mode_req_r};
				IDX_MODE_ACT: begin
					prdata_r <= {24'h000000, mode_act_r}; // R7
					err_r    <= pwrite;
				end
				IDX_FE_WIN:   prdata_r <= fe_win_r;
				IDX_SLIP:     prdata_r <= slip_r;
				default:      err_r    <= 1'b1;
			endcase
		end
	end

	assign prdata       = prdata_r;
	assign pready       = 1'b1;
	assign pslverr      = psel && penable && err_r;
	assign brake        = brake_r;
	assign drive_enable = drive_en_r;
	assign mode_active  = mode_act_r;

	// Checks
	logic quiet;
	assign quiet = !unrec_any && !fault_any && !pend_r;

	a_selftest_enter: assert property (@(posedge pclk) disable iff (!presetn) // R5
		state_r == ST_NOT_READY && self_test_pass && quiet |=> state_r == ST_DISABLED)
		else $error("self-test pass did not reach switch on disabled");
	a_unrec_lock: assert property (@(posedge pclk) disable iff (!presetn) // R6
		unrecoverable_err |=> (state_r == ST_NOT_READY) [*8])
		else $error("left not ready after unrecoverable error");
	a_fault_code: assert property (@(posedge pclk) disable iff (!presetn) // R4
		state_r == ST_FAULT |-> status_w[3:0] == 4'b1000 && !status_w[SW_DISABLED])
		else $error("fault state encoded wrongly");
	a_fault_hold: assert property (@(posedge pclk) disable iff (!presetn) // R3
		state_r == ST_FAULT && !fr_edge && !unrec_any |=> state_r == ST_FAULT)
		else $error("fault left without rising reset edge");
	a_enable_op: assert property (@(posedge pclk) disable iff (!presetn) // R2
		state_r == ST_SWITCHED_ON && cmd.enable_op && quiet |=> state_r == ST_OP_ENABLED)
		else $error("enable operation not taken");
	a_switch_on: assert property (@(posedge pclk) disable iff (!presetn) // R16
		state_r == ST_READY && cmd.switch_on && quiet |=> state_r == ST_SWITCHED_ON)
		else $error("switch on not taken from ready");
	a_ramp_hold: assert property (@(posedge pclk) disable iff (!presetn) // R17
		pend_r && pend_act_r != STOP_IMM && !motor_standstill && !unrec_any && !fault_any
		|=> $stable(state_r))
		else $error("state changed before standstill");
	a_halt_mode: assert property (@(posedge pclk) disable iff (!presetn) // R12
		state_r == ST_OP_ENABLED && ctrl_r[CW_HALT] && !halt_mode_ok && quiet
		&& ctrl_r[2:0] == 3'b111 && ctrl_r[CW_ENABLE_OP] |=> brake_r == '0)
		else $error("halt acted in a mode without halt");
	a_qs_quick: assert property (@(posedge pclk) disable iff (!presetn) // R8
		state_r == ST_OP_ENABLED && cmd.quick_stop && quiet && opt_qs_r == OPT_QUICK
		|=> state_r == ST_QUICK_STOP && brake_r.quick_ramp)
		else $error("quick stop option 2 not applied");
	a_fault_slow: assert property (@(posedge pclk) disable iff (!presetn) // R13
		state_r == ST_OP_ENABLED && fault_event && !unrec_any && opt_flt_r == OPT_SLOW
		&& !ferr_hit |=> state_r == ST_FAULT_REACT && brake_r.slow_ramp)
		else $error("fault option 1 not applied");
	a_monitor_off: assert property (@(posedge pclk) disable iff (!presetn) // R15
		state_r == ST_OP_ENABLED && follow_err_event
		&& (fe_win_r == FE_WIN_OFF || slip_r == SLIP_OFF)
		&& !fault_event && !unrec_any |=> state_r != ST_FAULT_REACT)
		else $error("following error acted while monitoring off");
	a_status_ro: assert property (@(posedge pclk) disable iff (!presetn) // R1
		setup && pwrite && idx == IDX_STATUS |=> pslverr)
		else $error("write to report word not refused");

	c_op_enabled: cover property (@(posedge pclk) disable iff (!presetn)
		state_r == ST_SWITCHED_ON ##1 state_r == ST_OP_ENABLED);
	c_ramp_done: cover property (@(posedge pclk) disable iff (!presetn)
		pend_r && pend_act_r == STOP_SLOW && motor_standstill);
	c_fault_reset: cover property (@(posedge pclk) disable iff (!presetn)
		state_r == ST_FAULT ##1 state_r == ST_DISABLED);

endmodule

// ===== verif/apb_master_model.sv
`timescale 1ns/100ps
// Fieldbus side of the block: a register bus master
module apb_master_model
	import drive_psm_pkg::*;
(
	input  wire logic              pclk,
	input  wire logic              pready,
	input  wire logic [31:0]       prdata,
	input  wire logic              pslverr,
	output logic                   psel,
	output logic                   penable,
	output logic                   pwrite,
	output logic      [ADDR_W-1:0] paddr,
	output logic      [31:0]       pwdata
);
	// Idle bus from time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
	end

	// One transfer; the request is held until pready is seen high
	task automatic xfer(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Released lines flip so stale values never look valid
		paddr <= ~paddr;
		pwdata <= ~pwdata;
	endtask
endmodule

// ===== verif/tb_top.sv
`timescale 1ns/100ps
module tb_top
	import drive_psm_pkg::*;
;
	logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata, prdata, rd;
	logic              self_test_pass, unrecoverable_err, fault_event, follow_err_event;
	logic              motor_standstill, drive_enable, monitor_enable, err;
	brake_t            brake;
	logic [7:0]        mode_active;
	int                failures = 0;
	int                check_count = 0;

	// Ordinary transitions: request word and expected report word
	localparam logic [31:0] row_cw [11] = '{32'h0f, 32'h06, 32'h07, 32'h0f, 32'h07, 32'h0f,
		32'h06, 32'h00, 32'h06, 32'h07, 32'h00};
	localparam logic [7:0]  row_st [11] = '{8'h40, 8'h21, 8'h23, 8'h27, 8'h23, 8'h27,
		8'h21, 8'h40, 8'h21, 8'h23, 8'h40};
	// Stops: option word, trigger, report while pending, report after standstill
	localparam logic [15:0] s_idx [5] = '{IDX_OPT_QS, IDX_OPT_SHUT, IDX_OPT_DOP, IDX_OPT_FLT,
		IDX_OPT_FERR};
	localparam logic [31:0] s_opt [5] = '{32'h2, 32'h1, 32'h1, 32'h1, 32'h2};
	localparam logic [31:0] s_cw  [5] = '{32'h02, 32'h06, 32'h07, 32'h0f, 32'h0f};
	localparam logic [7:0]  s_pend [5] = '{8'h07, 8'h27, 8'h27, 8'h0f, 8'h0f};
	// Shutdown word still stands after its ramp, so ready follows at once
	localparam logic [7:0]  s_end [5] = '{8'h40, 8'h21, 8'h40, 8'h08, 8'h08};

	drive_power_state_machine drive_power_state_machine_inst (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .self_test_pass(self_test_pass),
		.unrecoverable_err(unrecoverable_err), .fault_event(fault_event),
		.follow_err_event(follow_err_event), .motor_standstill(motor_standstill),
		.brake(brake), .drive_enable(drive_enable), .monitor_enable(monitor_enable),
		.mode_active(mode_active));
	apb_master_model master_inst (.pclk(pclk), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata));

	// Free-running bus clock
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr(input logic [15:0] idx, input logic [31:0] d);
		master_inst.xfer(1'b1, idx, d, rd, err);
	endtask
	task automatic rd_chk(input logic [15:0] idx, input logic [31:0] exp);
		master_inst.xfer(1'b0, idx, 32'h0, rd, err);
		check($sformatf("reg %h", idx), rd, exp);
	endtask
	// State follows one edge after the write; margin keeps reads clear of it
	task automatic st_chk(input logic [7:0] exp);
		repeat (3) @(posedge pclk);
		rd_chk(IDX_STATUS, {24'h0, exp});
	endtask
	task automatic to_op();
		wr(IDX_CTRL, 32'h06);
		wr(IDX_CTRL, 32'h07);
		wr(IDX_CTRL, 32'h0f);
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Hang guard, far beyond the few hundred cycles the sequence needs
	initial begin
		repeat (20000) @(posedge pclk);
		failures++;
		summarize();
	end

	// Main sequence
	initial begin
		presetn = 1'b0;
		self_test_pass = 1'b0;
		unrecoverable_err = 1'b0;
		fault_event = 1'b0;
		follow_err_event = 1'b0;
		motor_standstill = 1'b1;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		st_chk(8'h00);
		rd_chk(IDX_FE_WIN, RST_FE_WIN);
		rd_chk(IDX_OPT_QS, {16'h0, RST_OPT});
		check("pready", {31'h0, pready}, 32'h1);
		check("monitor", {31'h0, monitor_enable}, 32'h0);
		wr(IDX_STATUS, 32'h1);
		check("ro err", {31'h0, err}, 32'h1);
		rd_chk(16'h0001, 32'h0);
		check("unmapped err", {31'h0, err}, 32'h1);
		self_test_pass <= 1'b1;
		st_chk(8'h40);
		for (int i = 0; i < 11; i++) begin
			wr(IDX_CTRL, row_cw[i]);
			st_chk(row_st[i]);
		end
		wr(IDX_MODE_REQ, 32'h01);
		rd_chk(IDX_MODE_ACT, 32'h01);
		check("mode port", {24'h0, mode_active}, 32'h01);
		wr(IDX_MODE_ACT, 32'h03);
		check("mode ro err", {31'h0, err}, 32'h1);
		wr(IDX_FE_WIN, 32'h0);
		repeat (2) @(posedge pclk);
		check("monitor", {31'h0, monitor_enable}, 32'h1);
		// Ramped stops only, slow and quick; motor keeps turning until released
		for (int i = 0; i < 5; i++) begin
			motor_standstill <= 1'b0;
			wr(s_idx[i], s_opt[i]);
			to_op();
			wr(IDX_CTRL, s_cw[i]);
			if (i == 3)
				fault_event <= 1'b1;
			if (i == 4)
				follow_err_event <= 1'b1;
			@(posedge pclk);
			fault_event <= 1'b0;
			follow_err_event <= 1'b0;
			st_chk(s_pend[i]);
			check("brake", {29'h0, brake}, (s_opt[i] == 32'h2) ? 32'h1 : 32'h2);
			check("enable", {31'h0, drive_enable}, 32'h1);
			motor_standstill <= 1'b1;
			st_chk(s_end[i]);
			check("brake idle", {29'h0, brake}, 32'h0);
			check("enable off", {31'h0, drive_enable}, 32'h0);
			if (i > 2) begin
				wr(IDX_CTRL, 32'h00);
				st_chk(8'h08);
				wr(IDX_CTRL, 32'h80);
				st_chk(8'h40);
			end
		end
		// Halt acts only in the listed modes
		wr(IDX_OPT_HALT, 32'h1);
		to_op();
		wr(IDX_CTRL, 32'h10f);
		repeat (3) @(posedge pclk);
		check("halt brake", {29'h0, brake}, 32'h2);
		wr(IDX_MODE_REQ, 32'h06);
		repeat (3) @(posedge pclk);
		check("halt off mode", {29'h0, brake}, 32'h0);
		wr(IDX_CTRL, 32'h0f);
		wr(IDX_SLIP, SLIP_OFF);
		repeat (2) @(posedge pclk);
		check("monitor", {31'h0, monitor_enable}, 32'h0);
		// Following error ignored while the limit switches monitoring off
		follow_err_event <= 1'b1;
		@(posedge pclk);
		follow_err_event <= 1'b0;
		st_chk(8'h27);
		// Lock-out survives a passing self-test and later commands
		unrecoverable_err <= 1'b1;
		@(posedge pclk);
		unrecoverable_err <= 1'b0;
		st_chk(8'h00);
		wr(IDX_CTRL, 32'h06);
		st_chk(8'h00);
		check("lock brake", {29'h0, brake}, 32'h4);
		check("lock enable", {31'h0, drive_enable}, 32'h0);
		// Only a reset leaves the lock-out; self-test then passes again
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		check("reset brake", {29'h0, brake}, 32'h0);
		presetn <= 1'b1;
		st_chk(8'h40);
		rd_chk(IDX_FE_WIN, RST_FE_WIN);
		summarize();
	end
endmodule
